// File: design/timer8_pkg.sv
// Register map, field layout, encodings and state types of the 8-bit timer core
package timer8_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register bus geometry and register indices
   localparam int         ADDR_W       = 3;
   localparam int         DATA_W       = 8;
   localparam logic [2:0] OFF_CONTROL  = 3'h0;
   localparam logic [2:0] OFF_COUNTER  = 3'h1;
   localparam logic [2:0] OFF_COMPARE  = 3'h2;
   localparam logic [2:0] OFF_FLAGS    = 3'h3;
   localparam logic [2:0] OFF_MASK     = 3'h4;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int         CTRL_WGM_LSB = 0;
   localparam int         CTRL_CS_LSB  = 2;
   localparam int         CTRL_COM_LSB = 5;
   localparam int         CTRL_FORCE   = 7;
   localparam int         FLAG_OVF_BIT = 0;
   localparam int         FLAG_CMP_BIT = 1;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and counter landmarks
   localparam logic [7:0] COUNTER_RST  = 8'h00;
   localparam logic [7:0] COMPARE_RST  = 8'h00;
   localparam logic [9:0] PRESCALE_RST = 10'h000;
   localparam logic [7:0] BOTTOM_VAL   = 8'h00;
   localparam logic [7:0] MAX_VAL      = 8'hff;

   ////////////////////////////////////////////////////////////////////////////
   // Encodings
   typedef enum logic [1:0] {
      WGM_NORMAL    = 2'h0,
      WGM_PHASE_PWM = 2'h1,
      WGM_CTC       = 2'h2,
      WGM_FAST_PWM  = 2'h3
   } wgm_t;

   localparam logic [1:0] COM_NONE     = 2'h0;
   localparam logic [1:0] COM_TOGGLE   = 2'h1;
   localparam logic [1:0] COM_CLEAR    = 2'h2;
   localparam logic [1:0] COM_SET      = 2'h3;

   localparam logic [2:0] CS_STOP      = 3'h0;
   localparam logic [2:0] CS_DIV1      = 3'h1;
   localparam logic [2:0] CS_DIV8      = 3'h2;
   localparam logic [2:0] CS_DIV64     = 3'h3;
   localparam logic [2:0] CS_DIV256    = 3'h4;
   localparam logic [2:0] CS_DIV1024   = 3'h5;
   localparam logic [2:0] CS_EXT_FALL  = 3'h6;
   localparam logic [2:0] CS_EXT_RISE  = 3'h7;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic [1:0] compare_output_mode;
      logic [2:0] clock_select;
      wgm_t       waveform_mode_sel;
   } ctrl_t;

   typedef struct packed {
      logic       cmp;
      logic       ovf;
   } irq_bits_t;

   typedef struct packed {
      ctrl_t      ctrl;
      logic [7:0] counter_value;
      logic [7:0] compare_value;
      logic [7:0] compare_buf;
      logic       count_down;
      logic       compare_output;
      irq_bits_t  flags;
      irq_bits_t  mask;
      logic       match_block;
      logic [9:0] prescale;
      logic       ext_prev;
      logic [7:0] rdata;
   } state_t;

endpackage

// File: design/timer8_single_compare_core.sv
// 8-bit timer/counter with one output compare unit and a plain register port
//
// How it works
// - Counter and compare are 8-bit read/write registers.
// - Each request has a flag and mask bit.
// - Tick from prescaler or external pin edge.
// - Clock select zero stops the counter.
// - CPU counter write beats count or clear.
// - Mode bits pick clear, increment or decrement.
// - Bottom 0x00, max 0xFF, top per mode.
// - Equality sets compare flag on next tick.
// - Compare request needs enable and global enable.
// - Flag clears on service or written one.
// - Output follows match, modes, max and bottom.
// - Compare double buffered only in PWM modes.
// - Buffered compare loads at top or bottom.
// - Compare access hits buffer when double buffered.
// - Force strobe updates output, no flag, non-PWM.
// - Counter write blocks matches next tick.
// - Output state survives waveform mode changes.
// - Output mode bits act immediately, unbuffered.
// - Mode codes: normal 0, clear 2, fast 3.
// - Normal wraps 0xFF to 0x00, sets overflow.
// - Clear-on-match returns counter to zero.
// - Output mode zero never changes output.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
module timer8_single_compare_core
   import timer8_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_in,
   input  wire logic              nrst_in,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr_in,
   input  wire logic [DATA_W-1:0] reg_wdata_in,
   input  wire logic              reg_wr_in,
   input  wire logic              reg_rd_in,
   output logic      [DATA_W-1:0] reg_rdata_out,
   // Core interface
   input  wire logic              global_irq_enable_in,
   input  wire logic              compare_irq_ack_in,
   input  wire logic              overflow_irq_ack_in,
   output logic                   compare_irq_out,
   output logic                   overflow_irq_out,
   // Pins
   input  wire logic              external_count_pin_in,
   output logic                   compare_output_out
);

   ////////////////////////////////////////////////////////////////////////////
   // State and decode helpers

   state_t     st_r;
   state_t     st_nxt;
   logic       timer_tick;
   logic       pwm_mode;
   logic       match_event;
   logic       overflow_event;
   logic       load_buffer;
   logic       max_tick;
   ctrl_t      ctrl_wr;
   irq_bits_t  flag_clear;

   // Compare action shared by real matches and forced matches in non-PWM modes
   function automatic logic com_action(input logic [1:0] com, input logic cur);
      case (com)
         COM_TOGGLE: com_action = ~cur;
         COM_CLEAR:  com_action = 1'b0;
         COM_SET:    com_action = 1'b1;
         default:    com_action = cur;
      endcase
   endfunction

   function automatic logic is_pwm(input wgm_t mode);
      is_pwm = (mode == WGM_PHASE_PWM) || (mode == WGM_FAST_PWM);
   endfunction

   assign ctrl_wr.waveform_mode_sel   = wgm_t'(reg_wdata_in[CTRL_WGM_LSB +: 2]);
   assign ctrl_wr.clock_select        = reg_wdata_in[CTRL_CS_LSB +: 3];
   assign ctrl_wr.compare_output_mode = reg_wdata_in[CTRL_COM_LSB +: 2];

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb
   begin
      st_nxt         = st_r;
      timer_tick     = 1'b0;
      match_event    = 1'b0;
      overflow_event = 1'b0;
      load_buffer    = 1'b0;
      max_tick       = 1'b0;
      flag_clear     = '0;
      pwm_mode       = is_pwm(st_r.ctrl.waveform_mode_sel);

      st_nxt.rdata    = '0;
      st_nxt.prescale = st_r.prescale + 10'h001;
      st_nxt.ext_prev = external_count_pin_in;

      // Tick source; the prescaler runs free so a switch of ratio keeps phase
      case (st_r.ctrl.clock_select)
         CS_STOP:     timer_tick = 1'b0;
         CS_DIV1:     timer_tick = 1'b1;
         CS_DIV8:     timer_tick = &st_r.prescale[2:0];
         CS_DIV64:    timer_tick = &st_r.prescale[5:0];
         CS_DIV256:   timer_tick = &st_r.prescale[7:0];
         CS_DIV1024:  timer_tick = &st_r.prescale;
         CS_EXT_FALL: timer_tick = st_r.ext_prev & ~external_count_pin_in;
         CS_EXT_RISE: timer_tick = ~st_r.ext_prev & external_count_pin_in;
         default:     timer_tick = 1'b0;
      endcase

      // Match seen during the current count value, acted on at the tick
      match_event = timer_tick && (st_r.counter_value == st_r.compare_value)
                    && !st_r.match_block;
      max_tick    = timer_tick && (st_r.counter_value == MAX_VAL);

      if (timer_tick)
      begin
         st_nxt.match_block = 1'b0;
         case (st_r.ctrl.waveform_mode_sel)
            WGM_NORMAL:
            begin
               st_nxt.count_down    = 1'b0;
               st_nxt.counter_value = st_r.counter_value + 8'h01;
               overflow_event       = max_tick;
            end
            WGM_CTC:
            begin
               st_nxt.count_down = 1'b0;
               if (st_r.counter_value == st_r.compare_value)
               begin
                  st_nxt.counter_value = BOTTOM_VAL;
               end
               else
               begin
                  st_nxt.counter_value = st_r.counter_value + 8'h01;
               end
               overflow_event = max_tick && (st_r.compare_value != MAX_VAL);
            end
            WGM_FAST_PWM:
            begin
               st_nxt.count_down    = 1'b0;
               st_nxt.counter_value = st_r.counter_value + 8'h01;
               overflow_event       = max_tick;
               load_buffer          = max_tick;
            end
            WGM_PHASE_PWM:
            begin
               if (!st_r.count_down)
               begin
                  if (st_r.counter_value == MAX_VAL)
                  begin
                     st_nxt.count_down    = 1'b1;
                     st_nxt.counter_value = st_r.counter_value - 8'h01;
                     load_buffer          = 1'b1;
                  end
                  else
                  begin
                     st_nxt.counter_value = st_r.counter_value + 8'h01;
                  end
               end
               else
               begin
                  if (st_r.counter_value == BOTTOM_VAL)
                  begin
                     st_nxt.count_down    = 1'b0;
                     st_nxt.counter_value = st_r.counter_value + 8'h01;
                  end
                  else
                  begin
                     st_nxt.counter_value = st_r.counter_value - 8'h01;
                     overflow_event       = (st_r.counter_value == 8'h01);
                  end
               end
            end
            default:
            begin
               st_nxt.counter_value = st_r.counter_value;
            end
         endcase
      end

      // Waveform generator; output state is never reset by a mode change
      if (match_event)
      begin
         case (st_r.ctrl.waveform_mode_sel)
            WGM_FAST_PWM:
            begin
               if (st_r.ctrl.compare_output_mode == COM_CLEAR)
               begin
                  st_nxt.compare_output = 1'b0;
               end
               else if (st_r.ctrl.compare_output_mode == COM_SET)
               begin
                  st_nxt.compare_output = 1'b1;
               end
            end
            WGM_PHASE_PWM:
            begin
               if (st_r.ctrl.compare_output_mode == COM_CLEAR)
               begin
                  st_nxt.compare_output = st_r.count_down;
               end
               else if (st_r.ctrl.compare_output_mode == COM_SET)
               begin
                  st_nxt.compare_output = ~st_r.count_down;
               end
            end
            default:
            begin
               st_nxt.compare_output = com_action(st_r.ctrl.compare_output_mode,
                                                  st_r.compare_output);
            end
         endcase
      end

      // Extreme cases: bottom restores the level in fast PWM, and a compare
      // value at max or bottom pins the phase-correct output steady
      if (st_r.ctrl.waveform_mode_sel == WGM_FAST_PWM && max_tick)
      begin
         if (st_r.ctrl.compare_output_mode == COM_CLEAR)
         begin
            st_nxt.compare_output = 1'b1;
         end
         else if (st_r.ctrl.compare_output_mode == COM_SET)
         begin
            st_nxt.compare_output = 1'b0;
         end
      end
      if (st_r.ctrl.waveform_mode_sel == WGM_PHASE_PWM && timer_tick
          && st_r.ctrl.compare_output_mode[1])
      begin
         if (st_r.compare_value == MAX_VAL)
         begin
            st_nxt.compare_output = (st_r.ctrl.compare_output_mode == COM_CLEAR);
         end
         else if (st_r.compare_value == BOTTOM_VAL)
         begin
            st_nxt.compare_output = (st_r.ctrl.compare_output_mode == COM_SET);
         end
      end

      // Buffered compare moves to the active register at top or bottom
      if (load_buffer && pwm_mode)
      begin
         st_nxt.compare_value = st_r.compare_buf;
      end

      ////////////////////////////////////////////////////////////////////////
      // CPU writes come last so that they override counting and clearing

      if (reg_wr_in)
      begin
         case (reg_addr_in)
            OFF_CONTROL:
            begin
               st_nxt.ctrl = ctrl_wr;
               // Forced match only in non-PWM modes; flag and counter untouched
               if (reg_wdata_in[CTRL_FORCE] && !is_pwm(ctrl_wr.waveform_mode_sel))
               begin
                  st_nxt.compare_output = com_action(ctrl_wr.compare_output_mode,
                                                     st_nxt.compare_output);
               end
            end
            OFF_COUNTER:
            begin
               st_nxt.counter_value = reg_wdata_in;
               st_nxt.match_block   = 1'b1;
            end
            OFF_COMPARE:
            begin
               st_nxt.compare_buf = reg_wdata_in;
               if (!pwm_mode)
               begin
                  st_nxt.compare_value = reg_wdata_in;
               end
            end
            OFF_FLAGS:
            begin
               flag_clear.ovf = reg_wdata_in[FLAG_OVF_BIT];
               flag_clear.cmp = reg_wdata_in[FLAG_CMP_BIT];
            end
            OFF_MASK:
            begin
               st_nxt.mask.ovf = reg_wdata_in[FLAG_OVF_BIT];
               st_nxt.mask.cmp = reg_wdata_in[FLAG_CMP_BIT];
            end
            default:
            begin
               st_nxt.mask = st_r.mask;
            end
         endcase
      end

      // Service acknowledge also clears; a new event in the same cycle wins
      flag_clear.cmp = flag_clear.cmp | compare_irq_ack_in;
      flag_clear.ovf = flag_clear.ovf | overflow_irq_ack_in;
      st_nxt.flags.cmp = (st_r.flags.cmp & ~flag_clear.cmp) | match_event;
      st_nxt.flags.ovf = (st_r.flags.ovf & ~flag_clear.ovf) | overflow_event;

      ////////////////////////////////////////////////////////////////////////
      // Reads: data stand in the cycle after the strobe only

      if (reg_rd_in)
      begin
         case (reg_addr_in)
            OFF_CONTROL:
            begin
               st_nxt.rdata[CTRL_WGM_LSB +: 2] = st_r.ctrl.waveform_mode_sel;
               st_nxt.rdata[CTRL_CS_LSB +: 3]  = st_r.ctrl.clock_select;
               st_nxt.rdata[CTRL_COM_LSB +: 2] = st_r.ctrl.compare_output_mode;
            end
            OFF_COUNTER:
            begin
               st_nxt.rdata = st_r.counter_value;
            end
            OFF_COMPARE:
            begin
               st_nxt.rdata = pwm_mode ? st_r.compare_buf : st_r.compare_value;
            end
            OFF_FLAGS:
            begin
               st_nxt.rdata[FLAG_OVF_BIT] = st_r.flags.ovf;
               st_nxt.rdata[FLAG_CMP_BIT] = st_r.flags.cmp;
            end
            OFF_MASK:
            begin
               st_nxt.rdata[FLAG_OVF_BIT] = st_r.mask.ovf;
               st_nxt.rdata[FLAG_CMP_BIT] = st_r.mask.cmp;
            end
            default:
            begin
               st_nxt.rdata = '0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         st_r                     <= '0;
         st_r.counter_value       <= COUNTER_RST;
         st_r.compare_value       <= COMPARE_RST;
         st_r.compare_buf         <= COMPARE_RST;
         st_r.prescale            <= PRESCALE_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign reg_rdata_out      = st_r.rdata;
   assign compare_output_out = st_r.compare_output;
   // Requests are levels; the core's global enable gates them last
   assign compare_irq_out    = st_r.flags.cmp & st_r.mask.cmp & global_irq_enable_in;
   assign overflow_irq_out   = st_r.flags.ovf & st_r.mask.ovf & global_irq_enable_in;

endmodule // timer8_single_compare_core

// File: tb/timer8_single_compare_core_chk.sv
// Port-level assertions for the 8-bit timer core
module timer8_single_compare_core_chk
   import timer8_pkg::*;
(
   // Clock and reset
   input wire logic              clk_in,
   input wire logic              nrst_in,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr_in,
   input wire logic [DATA_W-1:0] reg_wdata_in,
   input wire logic              reg_wr_in,
   input wire logic              reg_rd_in,
   input wire logic [DATA_W-1:0] reg_rdata_out,
   // Core interface
   input wire logic              global_irq_enable_in,
   input wire logic              compare_irq_ack_in,
   input wire logic              overflow_irq_ack_in,
   input wire logic              compare_irq_out,
   input wire logic              overflow_irq_out,
   // Pins
   input wire logic              external_count_pin_in,
   input wire logic              compare_output_out
);
   logic       ctrl_wr;
   logic       stopped;
   logic [7:0] ctrl_sh_r;

   ////////////////////////////////////////////////////////////////////////////
   // Shadow of the control register; the force bit never reads back
   assign ctrl_wr = reg_wr_in && (reg_addr_in == OFF_CONTROL);
   assign stopped = (ctrl_sh_r[CTRL_CS_LSB +: 3] == CS_STOP);

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         ctrl_sh_r <= 8'h00;
      else if (ctrl_wr)
         ctrl_sh_r <= reg_wdata_in & 8'h7f;
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   a_irq_global: assert property (!global_irq_enable_in |-> !compare_irq_out && !overflow_irq_out)
      else $error("interrupt request without global enable");
   a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
      else $error("read data outside the read answer cycle");
   a_unmapped_read: assert property (reg_rd_in && reg_addr_in > OFF_MASK |=> reg_rdata_out == 8'h00)
      else $error("unmapped index read not zero");
   a_ctrl_readback: assert property (reg_rd_in && reg_addr_in == OFF_CONTROL
      |=> reg_rdata_out == ctrl_sh_r)
      else $error("control readback differs from written value");
   a_mask_off: assert property (reg_wr_in && reg_addr_in == OFF_MASK
      && !reg_wdata_in[FLAG_CMP_BIT] |=> !compare_irq_out)
      else $error("compare request not masked");
   a_flag_clear: assert property (stopped && reg_wr_in && reg_addr_in == OFF_FLAGS
      && reg_wdata_in[FLAG_CMP_BIT] |=> !compare_irq_out)
      else $error("compare flag not cleared by written one");
   a_stopped_hold: assert property (stopped && !ctrl_wr |=> $stable(compare_output_out))
      else $error("output moved while timer stopped");
   a_force_toggle: assert property (stopped && ctrl_wr && reg_wdata_in[CTRL_FORCE]
      && !reg_wdata_in[0] && reg_wdata_in[6:5] == COM_TOGGLE
      |=> compare_output_out != $past(compare_output_out))
      else $error("forced toggle missing");
   a_force_set: assert property (stopped && ctrl_wr && reg_wdata_in[CTRL_FORCE]
      && !reg_wdata_in[0] && reg_wdata_in[6:5] == COM_SET |=> compare_output_out)
      else $error("forced set missing");
   a_pwm_force_none: assert property (stopped && ctrl_wr && reg_wdata_in[CTRL_FORCE]
      && reg_wdata_in[0] |=> $stable(compare_output_out))
      else $error("force acted in a pwm mode");

   c_overflow_irq: cover property (overflow_irq_out);
   c_force: cover property (ctrl_wr && reg_wdata_in[CTRL_FORCE]);
   c_unmapped: cover property (reg_rd_in && reg_addr_in > OFF_MASK);
endmodule // timer8_single_compare_core_chk

// File: tb/tb.sv
// Self-checking register-level testbench for the 8-bit timer core
module tb
   import timer8_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic              clk_in;
   logic              nrst_in;
   logic [ADDR_W-1:0] reg_addr_in;
   logic [DATA_W-1:0] reg_wdata_in;
   logic              reg_wr_in;
   logic              reg_rd_in;
   logic [DATA_W-1:0] reg_rdata_out;
   logic              global_irq_enable_in;
   logic              compare_irq_ack_in;
   logic              overflow_irq_ack_in;
   logic              compare_irq_out;
   logic              overflow_irq_out;
   logic              external_count_pin_in;
   logic              compare_output_out;
   int                error_cnt;
   int                n_compared;
   int                cycles;
   int                div_tab [5] = '{1, 8, 64, 256, 1024};
   logic [1:0]        com_seq [5] = '{2'h3, 2'h1, 2'h2, 2'h1, 2'h0};
   logic              out_seq [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

   timer8_single_compare_core dut_u (.clk_in(clk_in), .nrst_in(nrst_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .global_irq_enable_in(global_irq_enable_in), .compare_irq_ack_in(compare_irq_ack_in),
      .overflow_irq_ack_in(overflow_irq_ack_in), .compare_irq_out(compare_irq_out),
      .overflow_irq_out(overflow_irq_out), .external_count_pin_in(external_count_pin_in),
      .compare_output_out(compare_output_out));

   initial
   begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register port tasks; a gap cycle between calls keeps strobes one driver a step
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_in);
      reg_wr_in    <= 1'b1;
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      @(posedge clk_in);
      reg_wr_in    <= 1'b0;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      reg_rd_in   <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_in);
      reg_rd_in   <= 1'b0;
      @(negedge clk_in);
      chk(reg_rdata_out, exp);
   endtask

   task automatic pins(input logic [7:0] exp);
      @(negedge clk_in);
      chk({5'h00, compare_output_out, compare_irq_out, overflow_irq_out}, exp);
   endtask

   // Counter sees n+2 ticks at divide-by-one between the two control writes
   task automatic run(input logic [7:0] ctrl, input int n);
      wr(OFF_CONTROL, ctrl);
      repeat (n) @(posedge clk_in);
      wr(OFF_CONTROL, ctrl & 8'he3);
   endtask

   task automatic end_of_test;
      $display("error_cnt=%0d n_compared=%0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         $display("BAD at %0t: run did not finish", $time);
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      nrst_in = 1'b0;
      reg_addr_in = 3'h0;
      reg_wdata_in = 8'h00;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      global_irq_enable_in = 1'b0;
      compare_irq_ack_in = 1'b0;
      overflow_irq_ack_in = 1'b0;
      external_count_pin_in = 1'b0;
      error_cnt = 0;
      n_compared = 0;
      cycles = 0;
      repeat (6) @(posedge clk_in);
      nrst_in <= 1'b1;
      for (int i = 0; i < 8; i++)
         rd(i[2:0], 8'h00);
      pins(8'h00);
      wr(OFF_COUNTER, 8'ha5);
      wr(OFF_COMPARE, 8'h5a);
      wr(3'h6, 8'hff);
      rd(3'h6, 8'h00);
      rd(OFF_COMPARE, 8'h5a);
      repeat (20) @(posedge clk_in);
      rd(OFF_COUNTER, 8'ha5);
      for (int i = 1; i < 6; i++)
      begin
         wr(OFF_COUNTER, 8'h30);
         run({3'h0, i[2:0], 2'h0}, 2 * div_tab[i - 1] - 2);
         rd(OFF_COUNTER, 8'h32);
      end
      for (int e = 6; e < 8; e++)
      begin
         wr(OFF_COUNTER, 8'h00);
         wr(OFF_CONTROL, {3'h0, e[2:0], 2'h0});
         repeat (3)
         begin
            @(posedge clk_in) external_count_pin_in <= 1'b1;
            repeat (2) @(posedge clk_in);
            external_count_pin_in <= 1'b0;
            repeat (2) @(posedge clk_in);
         end
         wr(OFF_CONTROL, 8'h00);
         rd(OFF_COUNTER, 8'h03);
      end
      // Wrap at the top with the compare value at maximum
      wr(OFF_COMPARE, 8'hff);
      wr(OFF_MASK, 8'h03);
      wr(OFF_COUNTER, 8'hfe);
      run(8'h04, 0);
      rd(OFF_COUNTER, 8'h00);
      rd(OFF_FLAGS, 8'h03);
      pins(8'h00);
      @(posedge clk_in) global_irq_enable_in <= 1'b1;
      pins(8'h03);
      wr(OFF_FLAGS, 8'h00);
      rd(OFF_FLAGS, 8'h03);
      wr(OFF_FLAGS, 8'h02);
      rd(OFF_FLAGS, 8'h01);
      @(posedge clk_in) overflow_irq_ack_in <= 1'b1;
      @(posedge clk_in) overflow_irq_ack_in <= 1'b0;
      rd(OFF_FLAGS, 8'h00);
      // Equal counter write hides the match on the first tick
      wr(OFF_COMPARE, 8'h20);
      wr(OFF_COUNTER, 8'h20);
      run(8'h04, 0);
      rd(OFF_COUNTER, 8'h22);
      rd(OFF_FLAGS, 8'h00);
      wr(OFF_COUNTER, 8'h1f);
      run(8'h04, 0);
      rd(OFF_FLAGS, 8'h02);
      pins(8'h02);
      @(posedge clk_in) compare_irq_ack_in <= 1'b1;
      @(posedge clk_in) compare_irq_ack_in <= 1'b0;
      rd(OFF_FLAGS, 8'h00);
      wr(OFF_CONTROL, 8'h04);
      wr(OFF_COUNTER, 8'h80);
      wr(OFF_CONTROL, 8'h00);
      rd(OFF_COUNTER, 8'h82);
      // Clear-on-match
      wr(OFF_COMPARE, 8'h05);
      wr(OFF_COUNTER, 8'h04);
      run(8'h06, 0);
      rd(OFF_COUNTER, 8'h00);
      rd(OFF_FLAGS, 8'h02);
      wr(OFF_FLAGS, 8'h03);
      for (int k = 0; k < 5; k++)
      begin
         wr(OFF_CONTROL, {1'b1, com_seq[k], 5'h00});
         pins({5'h00, out_seq[k], 2'h0});
      end
      rd(OFF_FLAGS, 8'h00);
      rd(OFF_COUNTER, 8'h00);
      rd(OFF_CONTROL, 8'h00);
      // Fast pwm: writes land in the buffer until the top is passed
      wr(OFF_CONTROL, 8'hc3);
      pins(8'h04);
      wr(OFF_COMPARE, 8'h40);
      rd(OFF_COMPARE, 8'h40);
      wr(OFF_COUNTER, 8'h04);
      run(8'h07, 0);
      rd(OFF_FLAGS, 8'h02);
      wr(OFF_COUNTER, 8'hfe);
      run(8'h07, 0);
      wr(OFF_FLAGS, 8'h03);
      wr(OFF_COUNTER, 8'h3e);
      run(8'h07, 1);
      rd(OFF_FLAGS, 8'h02);
      rd(OFF_COUNTER, 8'h41);
      pins(8'h06);
      wr(OFF_COUNTER, 8'hfe);
      run(8'h05, 0);
      rd(OFF_COUNTER, 8'hfe);
      wr(OFF_MASK, 8'h00);
      pins(8'h04);
      // Non-inverting fast pwm: cleared at the match, set again at bottom
      wr(OFF_COUNTER, 8'h3e);
      run(8'h47, 1);
      pins(8'h00);
      wr(OFF_COUNTER, 8'hfe);
      run(8'h47, 0);
      pins(8'h04);
      end_of_test();
   end
endmodule // tb

bind timer8_single_compare_core timer8_single_compare_core_chk chk_u (.clk_in(clk_in),
   .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
   .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
   .global_irq_enable_in(global_irq_enable_in), .compare_irq_ack_in(compare_irq_ack_in),
   .overflow_irq_ack_in(overflow_irq_ack_in), .compare_irq_out(compare_irq_out),
   .overflow_irq_out(overflow_irq_out), .external_count_pin_in(external_count_pin_in),
   .compare_output_out(compare_output_out));
